//--- src/pic_regs.svh
// Functional notes
// - Pair type bit 1 sets period flag on period match, 0 on underflow.
// - Period type bit only acts in center-aligned mode; edge-aligned always uses underflow.
// - Duty interrupt enable bits 8..11 gate duty flags onto the interrupt request.
// - Period interrupt enable bits 0..3 gate period flags onto the interrupt request.
// - Duty flag sets when down-count reaches compare value; write one clears.
// - Edge-aligned with compare equal to period: duty flag is not set.
// - Period flag sets on the selected counter condition; write one clears.
// - Falling input edge latches counter into falling capture, sets falling indicator.
// - Rising input edge latches counter into rising capture, sets rising indicator.
// - Indicators clear when written bit equals compat bit; other values leave them.
// - Capture flag sets on enabled rising or falling edge; write one clears.
// - Capture enabled: counter latched into rising/falling capture on edges.
// - Capture disabled: no capture update and capture interrupt suppressed.
// - Falling interrupt enable set: falling edge raises capture interrupt request.
// - Rising interrupt enable set: rising edge raises capture interrupt request.
// - Inverter bit set inverts the pin before edge detection.
// - Input path enable low: capture input treated as constant zero.
`ifndef PIC_REGS_SVH
`define PIC_REGS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define PIC_OFS_COMPAT 8'h3C
`define PIC_OFS_IRQ_EN 8'h40
`define PIC_OFS_IRQ_FLAG 8'h44
`define PIC_OFS_CAP_CTL 8'h50
`define PIC_OFS_RISE0 8'h58
`define PIC_OFS_FALL0 8'h5C
`define PIC_OFS_RISE1 8'h60
`define PIC_OFS_FALL1 8'h64
`define PIC_OFS_CAP_IN_EN 8'h78

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PIC_IE_PERIOD_LSB 0
`define PIC_IE_DUTY_LSB 8
`define PIC_IE_TYPE_LSB 16
`define PIC_FL_PERIOD_LSB 0
`define PIC_FL_DUTY_LSB 8
`define PIC_CCR_STRIDE 16
`define PIC_CCR_INV 0
`define PIC_CCR_RIE 1
`define PIC_CCR_FIE 2
`define PIC_CCR_FEN 3
`define PIC_CCR_CAPIF 4
`define PIC_CCR_RIND 6
`define PIC_CCR_FIND 7

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define PIC_RST_NIB 4'h0
`define PIC_RST_PAIR 2'h0
`define PIC_RST_BIT 1'h0
`define PIC_RST_CNT 16'h0000
`define PIC_RST_WORD 32'h0000_0000

`endif

//--- src/pic_pkg.sv
// ----------------------------------------------------------------
// Shared types
// ----------------------------------------------------------------
package pic_pkg;
    typedef logic [15:0] pic_cnt_t;
    typedef logic [31:0] pic_word_t;
    typedef logic [7:0] pic_addr_t;
endpackage : pic_pkg

//--- src/pic_capture_ch.sv
`timescale 1ns/1ps
`include "pic_regs.svh"

module pic_capture_ch (
    input wire logic pclk, // PWM clock
    input wire logic presetn, // Async reset, active low
    input wire logic pin, // Raw capture pin
    input wire logic path_en, // Input path enable
    input wire logic invert, // Input inverter
    input wire logic func_en, // Capture function enable
    input wire pic_pkg::pic_cnt_t cnt, // Down-counter value
    output logic rise_evt, // Qualified rising edge pulse
    output logic fall_evt, // Qualified falling edge pulse
    output pic_pkg::pic_cnt_t rise_val, // Rising capture value
    output pic_pkg::pic_cnt_t fall_val // Falling capture value
);
    // ----------------------------------------------------------------
    // Synchroniser and edge detect
    // ----------------------------------------------------------------
    logic meta_reg;
    logic sync_reg;
    logic prev_reg;
    logic cond;

    // Two stages; only the second stage is looked at
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_reg <= `PIC_RST_BIT;
            sync_reg <= `PIC_RST_BIT;
        end else begin
            meta_reg <= pin;
            sync_reg <= meta_reg;
        end
    end

    // Invert then gate; flipping invert alone also looks like an edge
    assign cond = path_en & (sync_reg ^ invert);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_reg <= `PIC_RST_BIT;
        end else begin
            prev_reg <= cond;
        end
    end

    // One pulse per transition, only while capture runs
    assign rise_evt = func_en & cond & ~prev_reg;
    assign fall_evt = func_en & ~cond & prev_reg;

    // ----------------------------------------------------------------
    // Capture latches
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rise_val <= `PIC_RST_CNT;
        end else if (rise_evt) begin
            rise_val <= cnt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fall_val <= `PIC_RST_CNT;
        end else if (fall_evt) begin
            fall_val <= cnt;
        end
    end
endmodule : pic_capture_ch

//--- src/pic_top.sv
`timescale 1ns/1ps
`include "pic_regs.svh"

module pic_top (
    input wire logic pclk, // PWM clock, 10 MHz
    input wire logic presetn, // Async reset, active low
    input wire pic_pkg::pic_addr_t paddr, // APB byte address
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction, 1 = write
    input wire pic_pkg::pic_word_t pwdata, // APB write data
    output pic_pkg::pic_word_t prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error for unmapped address
    input wire logic [3:0] cnt_underflow, // Counter underflow pulse per channel
    input wire logic [3:0] cnt_period_match, // Counter equals period value pulse
    input wire logic [3:0] cnt_duty_match, // Down-count reached compare value pulse
    input wire logic [3:0] cmp_eq_period, // Compare value equals period value
    input wire logic [1:0] pair_center, // Pair runs center-aligned
    input wire pic_pkg::pic_cnt_t cnt_ch0, // Channel 0 down-counter
    input wire pic_pkg::pic_cnt_t cnt_ch1, // Channel 1 down-counter
    input wire logic [1:0] cap_pin, // Capture input pins
    output logic pwm_irq, // Period or duty interrupt request
    output logic cap_irq // Capture interrupt request
);
    // ----------------------------------------------------------------
    // Register state
    // ----------------------------------------------------------------
    logic [3:0] period_irq_enable_reg;
    logic [3:0] duty_irq_enable_reg;
    logic [1:0] period_irq_type_reg; // [0] low pair, [1] high pair
    logic [3:0] period_flag_reg;
    logic [3:0] duty_flag_reg;
    logic clear_polarity_compat_reg;
    logic [1:0] capture_input_path_enable_reg;
    logic [1:0] input_invert_reg;
    logic [1:0] rising_irq_enable_reg;
    logic [1:0] falling_irq_enable_reg;
    logic [1:0] capture_func_enable_reg;
    logic [1:0] capture_irq_flag_reg;
    logic [1:0] rising_latched_ind_reg;
    logic [1:0] falling_latched_ind_reg;

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    logic setup;
    logic wr;
    logic sel_compat;
    logic sel_irq_en;
    logic sel_irq_flag;
    logic sel_cap_ctl;
    logic sel_cap_in_en;
    pic_pkg::pic_word_t prdata_next;
    logic mapped_next;

    // Setup phase prepares the answer; access edge commits writes
    assign setup = psel & ~penable;
    assign wr = psel & penable & pready & pwrite;
    assign sel_compat = (paddr == `PIC_OFS_COMPAT);
    assign sel_irq_en = (paddr == `PIC_OFS_IRQ_EN);
    assign sel_irq_flag = (paddr == `PIC_OFS_IRQ_FLAG);
    assign sel_cap_ctl = (paddr == `PIC_OFS_CAP_CTL);
    assign sel_cap_in_en = (paddr == `PIC_OFS_CAP_IN_EN);

    // ----------------------------------------------------------------
    // Capture channels
    // ----------------------------------------------------------------
    logic [1:0] rise_evt;
    logic [1:0] fall_evt;
    pic_pkg::pic_cnt_t rise_val [2];
    pic_pkg::pic_cnt_t fall_val [2];
    pic_pkg::pic_cnt_t cnt_sel [2];

    assign cnt_sel[0] = cnt_ch0;
    assign cnt_sel[1] = cnt_ch1;

    // Per-channel pin conditioning, edge detect and latches
    for (genvar c = 0; c < 2; c++) begin : g_cap
        pic_capture_ch u_ch (
            .pclk(pclk),
            .presetn(presetn),
            .pin(cap_pin[c]),
            .path_en(capture_input_path_enable_reg[c]),
            .invert(input_invert_reg[c]),
            .func_en(capture_func_enable_reg[c]),
            .cnt(cnt_sel[c]),
            .rise_evt(rise_evt[c]),
            .fall_evt(fall_evt[c]),
            .rise_val(rise_val[c]),
            .fall_val(fall_val[c])
        );
    end

    // ----------------------------------------------------------------
    // Read mux
    // ----------------------------------------------------------------
    always_comb begin
        prdata_next = `PIC_RST_WORD;
        mapped_next = 1'b1;
        unique case (paddr)
            `PIC_OFS_COMPAT: begin
                prdata_next[0] = clear_polarity_compat_reg;
            end
            `PIC_OFS_IRQ_EN: begin
                prdata_next[`PIC_IE_PERIOD_LSB +: 4] = period_irq_enable_reg;
                prdata_next[`PIC_IE_DUTY_LSB +: 4] = duty_irq_enable_reg;
                prdata_next[`PIC_IE_TYPE_LSB +: 2] = period_irq_type_reg;
            end
            `PIC_OFS_IRQ_FLAG: begin
                prdata_next[`PIC_FL_PERIOD_LSB +: 4] = period_flag_reg;
                prdata_next[`PIC_FL_DUTY_LSB +: 4] = duty_flag_reg;
            end
            `PIC_OFS_CAP_CTL: begin
                for (int c = 0; c < 2; c++) begin
                    prdata_next[c*`PIC_CCR_STRIDE + `PIC_CCR_INV] = input_invert_reg[c];
                    prdata_next[c*`PIC_CCR_STRIDE + `PIC_CCR_RIE] = rising_irq_enable_reg[c];
                    prdata_next[c*`PIC_CCR_STRIDE + `PIC_CCR_FIE] = falling_irq_enable_reg[c];
                    prdata_next[c*`PIC_CCR_STRIDE + `PIC_CCR_FEN] = capture_func_enable_reg[c];
                    prdata_next[c*`PIC_CCR_STRIDE + `PIC_CCR_CAPIF] = capture_irq_flag_reg[c];
                    prdata_next[c*`PIC_CCR_STRIDE + `PIC_CCR_RIND] = rising_latched_ind_reg[c];
                    prdata_next[c*`PIC_CCR_STRIDE + `PIC_CCR_FIND] = falling_latched_ind_reg[c];
                end
            end
            `PIC_OFS_RISE0: prdata_next[15:0] = rise_val[0];
            `PIC_OFS_FALL0: prdata_next[15:0] = fall_val[0];
            `PIC_OFS_RISE1: prdata_next[15:0] = rise_val[1];
            `PIC_OFS_FALL1: prdata_next[15:0] = fall_val[1];
            `PIC_OFS_CAP_IN_EN: begin
                prdata_next[1:0] = capture_input_path_enable_reg;
            end
            default: mapped_next = 1'b0;
        endcase
    end

    // One wait-free access cycle; data sampled at the setup edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= `PIC_RST_BIT;
            pslverr <= `PIC_RST_BIT;
            prdata <= `PIC_RST_WORD;
        end else begin
            pready <= setup;
            pslverr <= setup & ~mapped_next;
            prdata <= (setup & ~pwrite) ? prdata_next : `PIC_RST_WORD;
        end
    end

    // ----------------------------------------------------------------
    // Control registers
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            period_irq_enable_reg <= `PIC_RST_NIB;
            duty_irq_enable_reg <= `PIC_RST_NIB;
            period_irq_type_reg <= `PIC_RST_PAIR;
        end else if (wr && sel_irq_en) begin
            period_irq_enable_reg <= pwdata[`PIC_IE_PERIOD_LSB +: 4];
            duty_irq_enable_reg <= pwdata[`PIC_IE_DUTY_LSB +: 4];
            period_irq_type_reg <= pwdata[`PIC_IE_TYPE_LSB +: 2];
        end
    end

    // Compat bit picks which written value clears the indicators
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clear_polarity_compat_reg <= `PIC_RST_BIT;
        end else if (wr && sel_compat) begin
            clear_polarity_compat_reg <= pwdata[0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            capture_input_path_enable_reg <= `PIC_RST_PAIR;
        end else if (wr && sel_cap_in_en) begin
            capture_input_path_enable_reg <= pwdata[1:0];
        end
    end

    // Plain read/write capture control fields
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            input_invert_reg <= `PIC_RST_PAIR;
            rising_irq_enable_reg <= `PIC_RST_PAIR;
            falling_irq_enable_reg <= `PIC_RST_PAIR;
            capture_func_enable_reg <= `PIC_RST_PAIR;
        end else if (wr && sel_cap_ctl) begin
            for (int c = 0; c < 2; c++) begin
                input_invert_reg[c] <= pwdata[c*`PIC_CCR_STRIDE + `PIC_CCR_INV];
                rising_irq_enable_reg[c] <= pwdata[c*`PIC_CCR_STRIDE + `PIC_CCR_RIE];
                falling_irq_enable_reg[c] <= pwdata[c*`PIC_CCR_STRIDE + `PIC_CCR_FIE];
                capture_func_enable_reg[c] <= pwdata[c*`PIC_CCR_STRIDE + `PIC_CCR_FEN];
            end
        end
    end

    // ----------------------------------------------------------------
    // Period and duty events
    // ----------------------------------------------------------------
    logic [3:0] period_evt;
    logic [3:0] duty_evt;
    logic [3:0] period_clr;
    logic [3:0] duty_clr;

    // Type bit is meaningless edge-aligned, so underflow is used there
    for (genvar n = 0; n < 4; n++) begin : g_evt
        assign period_evt[n] = (pair_center[n/2] && period_irq_type_reg[n/2]) ?
            cnt_period_match[n] : cnt_underflow[n];
        // Edge-aligned with compare equal to period gives no duty flag
        assign duty_evt[n] = cnt_duty_match[n] &
            ~(~pair_center[n/2] & cmp_eq_period[n]);
    end

    assign period_clr = (wr && sel_irq_flag) ? pwdata[`PIC_FL_PERIOD_LSB +: 4] : `PIC_RST_NIB;
    assign duty_clr = (wr && sel_irq_flag) ? pwdata[`PIC_FL_DUTY_LSB +: 4] : `PIC_RST_NIB;

    // Sticky flags; a set in the clearing cycle survives
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            period_flag_reg <= `PIC_RST_NIB;
        end else begin
            period_flag_reg <= (period_flag_reg & ~period_clr) | period_evt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            duty_flag_reg <= `PIC_RST_NIB;
        end else begin
            duty_flag_reg <= (duty_flag_reg & ~duty_clr) | duty_evt;
        end
    end

    // ----------------------------------------------------------------
    // Capture flags and indicators
    // ----------------------------------------------------------------
    logic [1:0] cap_set;
    logic [1:0] cap_clr;
    logic [1:0] rind_clr;
    logic [1:0] find_clr;

    for (genvar c = 0; c < 2; c++) begin : g_capflag
        // Events already vanish when the channel's capture is off
        assign cap_set[c] = (rise_evt[c] & rising_irq_enable_reg[c]) |
            (fall_evt[c] & falling_irq_enable_reg[c]);
        assign cap_clr[c] = wr & sel_cap_ctl &
            pwdata[c*`PIC_CCR_STRIDE + `PIC_CCR_CAPIF];
        // Clear only when the written bit matches the compat polarity
        assign rind_clr[c] = wr & sel_cap_ctl &
            (pwdata[c*`PIC_CCR_STRIDE + `PIC_CCR_RIND] == clear_polarity_compat_reg);
        assign find_clr[c] = wr & sel_cap_ctl &
            (pwdata[c*`PIC_CCR_STRIDE + `PIC_CCR_FIND] == clear_polarity_compat_reg);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            capture_irq_flag_reg <= `PIC_RST_PAIR;
        end else begin
            capture_irq_flag_reg <= (capture_irq_flag_reg & ~cap_clr) | cap_set;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rising_latched_ind_reg <= `PIC_RST_PAIR;
        end else begin
            rising_latched_ind_reg <= (rising_latched_ind_reg & ~rind_clr) | rise_evt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            falling_latched_ind_reg <= `PIC_RST_PAIR;
        end else begin
            falling_latched_ind_reg <= (falling_latched_ind_reg & ~find_clr) | fall_evt;
        end
    end

    // ----------------------------------------------------------------
    // Interrupt requests
    // ----------------------------------------------------------------
    // Registered so the request lags its flag by one cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwm_irq <= `PIC_RST_BIT;
            cap_irq <= `PIC_RST_BIT;
        end else begin
            pwm_irq <= |((period_flag_reg & period_irq_enable_reg) |
                         (duty_flag_reg & duty_irq_enable_reg));
            cap_irq <= |(capture_irq_flag_reg & capture_func_enable_reg);
        end
    end
endmodule : pic_top

//--- test/pic_checker.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Port checker
// ------------------------------------------------------------
module pic_checker (
    input wire logic pclk, // Clock
    input wire logic presetn, // Reset, active low
    input wire pic_pkg::pic_addr_t paddr, // Address
    input wire logic psel, // Select
    input wire logic penable, // Enable
    input wire logic pwrite, // Direction
    input wire pic_pkg::pic_word_t pwdata, // Write data
    input wire pic_pkg::pic_word_t prdata, // Read data
    input wire logic pready, // Ready
    input wire logic pslverr, // Error
    input wire logic [3:0] cnt_underflow, // Underflow pulses
    input wire logic [3:0] cnt_period_match, // Period match pulses
    input wire logic [3:0] cnt_duty_match, // Duty match pulses
    input wire logic [3:0] cmp_eq_period, // Compare equals period
    input wire logic [1:0] pair_center, // Center-aligned pairs
    input wire pic_pkg::pic_cnt_t cnt_ch0, // Counter 0
    input wire pic_pkg::pic_cnt_t cnt_ch1, // Counter 1
    input wire logic [1:0] cap_pin, // Capture pins
    input wire logic pwm_irq, // PWM request
    input wire logic cap_irq // Capture request
);
    logic [1:0] pin_q_reg;
    logic [7:0] act_reg;
    wire logic wr_now = psel && penable && pwrite && pready;
    wire logic pwm_cause = (|cnt_underflow) || (|cnt_period_match) || (|cnt_duty_match) || wr_now;
    // History of pin moves and writes; conditioning writes can fake an edge too
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_q_reg <= 2'h0;
            act_reg <= 8'h00;
        end else begin
            pin_q_reg <= cap_pin;
            act_reg <= {act_reg[6:0], (cap_pin != pin_q_reg) || wr_now};
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_READY_AFTER_SETUP: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    AST_READY_ONE_CYCLE: assert property (pready |=> !pready)
        else $error("pready held too long");
    AST_READY_IN_ACCESS: assert property (pready |-> psel && penable)
        else $error("pready outside access");
    AST_ERR_WITH_READY: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    AST_RDATA_IDLE: assert property (!pready |-> prdata == 32'h0000_0000)
        else $error("prdata not zero when idle");
    AST_PWM_IRQ_CAUSE: assert property ($rose(pwm_irq) |-> $past(pwm_cause, 2))
        else $error("pwm request rose without cause");
    AST_PWM_IRQ_DROP: assert property ($fell(pwm_irq) |-> $past(wr_now, 2))
        else $error("pwm request fell without write");
    AST_CAP_IRQ_CAUSE: assert property ($rose(cap_irq) |-> |act_reg[7:1])
        else $error("capture request rose without edge");
    AST_CAP_IRQ_DROP: assert property ($fell(cap_irq) |-> $past(wr_now, 2))
        else $error("capture request fell without write");
    // Main scenarios reached
    cover property ($rose(pwm_irq));
    cover property ($rose(cap_irq));
    cover property (pslverr);
endmodule : pic_checker

bind pic_top pic_checker u_chk (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
    .prdata, .pready, .pslverr, .cnt_underflow, .cnt_period_match, .cnt_duty_match,
    .cmp_eq_period, .pair_center, .cnt_ch0, .cnt_ch1, .cap_pin, .pwm_irq, .cap_irq);

//--- test/pic_pin_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Capture pin source
// ------------------------------------------------------------
module pic_pin_model (
    input wire logic pclk, // Clock
    input wire logic [1:0] level_req, // Requested pin levels
    output logic [1:0] cap_pin // Driven capture pins
);
    // Pins move just after an edge, so each level lasts whole cycles
    initial cap_pin = 2'h0;
    always @(posedge pclk) begin
        cap_pin <= level_req;
    end
endmodule : pic_pin_model

//--- test/pic_top_bench.sv
`timescale 1ns/1ps
`define CHK(g, e) begin \
    total_checks++; \
    if ((g) !== (e)) begin \
        miscompares++; \
        $display("[ERR] %0t got %h exp %h", $time, (g), (e)); \
    end \
end
module pic_top_bench;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, pwm_irq, cap_irq, err, compat;
    pic_pkg::pic_addr_t paddr;
    pic_pkg::pic_word_t pwdata, prdata, rd, exp_ctl;
    logic [3:0] cnt_underflow, cnt_period_match, cnt_duty_match, cmp_eq_period;
    logic [1:0] pair_center, cap_pin, level_req;
    pic_pkg::pic_cnt_t cnt_ch0, cnt_ch1;
    pic_pkg::pic_cnt_t exp_val[4] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000};
    pic_pkg::pic_addr_t offs[9] = '{8'h3C, 8'h40, 8'h44, 8'h50, 8'h58, 8'h5C, 8'h60, 8'h64, 8'h78};
    int miscompares, total_checks, seed_dummy;
    pic_top u_dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
        .pready, .pslverr, .cnt_underflow, .cnt_period_match, .cnt_duty_match,
        .cmp_eq_period, .pair_center, .cnt_ch0, .cnt_ch1, .cap_pin, .pwm_irq, .cap_irq);
    pic_pin_model u_pins (.pclk(pclk), .level_req(level_req), .cap_pin(cap_pin));
    // ------------------------------------------------------------
    // Clock and bus tasks
    // ------------------------------------------------------------
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : print_verdict
    // One APB transfer; waits on pready under a bound rather than a fixed latency
    task automatic apb(input logic wr, input pic_pkg::pic_addr_t a, input pic_pkg::pic_word_t wd);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= wr;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 16) begin
            miscompares++;
            print_verdict();
        end
    endtask : apb
    task automatic rdchk(input pic_pkg::pic_addr_t a, input pic_pkg::pic_word_t e);
        apb(1'b0, a, 32'h0000_0000);
        `CHK(rd, e)
    endtask : rdchk
    task automatic pulse(input int ev, input int ch);
        @(posedge pclk);
        cnt_underflow <= (ev == 0) ? 4'h1 << ch : 4'h0;
        cnt_period_match <= (ev == 1) ? 4'h1 << ch : 4'h0;
        cnt_duty_match <= (ev == 2) ? 4'h1 << ch : 4'h0;
        @(posedge pclk);
        cnt_underflow <= 4'h0;
        cnt_period_match <= 4'h0;
        cnt_duty_match <= 4'h0;
    endtask : pulse
    // Reference capture behaviour on a conditioned edge
    task automatic edge_model(input int ch, input logic rising, input logic [3:0] cfg);
        if (cfg[3]) begin
            exp_val[2 * ch + (rising ? 0 : 1)] = ch ? cnt_ch1 : cnt_ch0;
            exp_ctl[16 * ch + (rising ? 6 : 7)] = 1'b1;
            if (cfg[rising ? 1 : 2]) exp_ctl[16 * ch + 4] = 1'b1;
        end
    endtask : edge_model
    // Conditioning writes may fake an edge, so config goes in twice and the second write clears the faked flags
    task automatic cap_case(input int ch, input logic [3:0] cfg, input logic pen);
        pic_pkg::pic_word_t clr;
        logic c0, c1;
        clr = compat ? 32'h00D0_00D0 : 32'h0010_0010;
        wr_cfg: begin
            apb(1'b1, 8'h50, clr);
            apb(1'b1, 8'h78, {30'h0, pen, pen});
            apb(1'b1, 8'h50, clr | ({28'h0, cfg} << (16 * ch)));
            repeat (6) @(posedge pclk);
            apb(1'b1, 8'h50, clr | ({28'h0, cfg} << (16 * ch)));
        end
        exp_ctl = {28'h0, cfg} << (16 * ch);
        c0 = pen & cfg[0];
        for (int k = 0; k < 2; k++) begin
            cnt_ch0 <= 16'($urandom);
            cnt_ch1 <= 16'($urandom);
            level_req[ch] <= ~k[0];
            repeat (6) @(posedge pclk);
            c1 = pen & (~k[0] ^ cfg[0]);
            if (c1 != c0) edge_model(ch, c1, cfg);
            c0 = c1;
        end
        rdchk(8'h50, exp_ctl);
        rdchk(8'h58 + 8'(8 * ch), {16'h0, exp_val[2 * ch]});
        rdchk(8'h5C + 8'(8 * ch), {16'h0, exp_val[2 * ch + 1]});
        `CHK(cap_irq, exp_ctl[16 * ch + 4] & cfg[3])
    endtask : cap_case
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {psel, penable, pwrite, compat} = 4'h0;
        {paddr, pwdata, exp_ctl} = 72'h0;
        {cnt_underflow, cnt_period_match, cnt_duty_match, cmp_eq_period} = 16'h0000;
        {pair_center, level_req, cnt_ch0, cnt_ch1} = 36'h0;
        presetn = 1'b0;
        seed_dummy = $urandom(32'hEFF4AA1E);
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        foreach (offs[i]) rdchk(offs[i], 32'h0000_0000);
        apb(1'b0, 8'h80, 32'h0000_0000);
        `CHK(err, 1'b1)
        $display("test reset and map done");
        // Every event kind, channel, alignment and type bit, with random gating
        for (int i = 0; i < 48; i++) begin
            int ch, ev, ctr, typ;
            logic set;
            pic_pkg::pic_word_t ie, fl;
            ch = i % 4;
            ev = i / 16;
            ctr = (i / 4) % 2;
            typ = (i / 8) % 2;
            pair_center <= {ctr[0], ctr[0]};
            cmp_eq_period <= 4'($urandom);
            ie = ($urandom & 32'h0000_0F0F) | (typ << (16 + ch / 2));
            apb(1'b1, 8'h40, ie);
            rdchk(8'h40, ie);
            apb(1'b1, 8'h44, 32'h0000_0F0F);
            pulse(ev, ch);
            if (ev == 0) set = !(ctr && typ);
            else if (ev == 1) set = ctr && typ;
            else set = ctr || !cmp_eq_period[ch];
            fl = {31'h0, set} << ((ev == 2 ? 8 : 0) + ch);
            rdchk(8'h44, fl);
            `CHK(pwm_irq, |(fl & ie))
            apb(1'b1, 8'h44, fl ^ 32'h0000_0F0F);
            rdchk(8'h44, fl);
        end
        $display("test period and duty flags done");
        compat = 1'b1;
        apb(1'b1, 8'h3C, 32'h0000_0001);
        for (int i = 0; i < 10; i++) cap_case(i % 2, {i != 5 && i != 6, 2'($urandom), i[1]}, i < 8);
        $display("test capture done");
        compat = 1'b0;
        apb(1'b1, 8'h3C, 32'h0000_0000);
        cap_case(0, 4'hE, 1'b1);
        apb(1'b1, 8'h50, 32'h0000_00CE);
        rdchk(8'h50, exp_ctl);
        apb(1'b1, 8'h50, 32'h0000_001E);
        rdchk(8'h50, 32'h0000_000E);
        $display("test clear polarity done");
        print_verdict();
    end
endmodule : pic_top_bench
